//--- hw/elpa_top.sv
module elpa_top (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        rd_en,
  input  wire logic        wr_en,
  input  wire logic [4:0]  reg_index,
  input  wire logic [31:0] wr_data,
  output logic             rd_valid,
  output logic             wr_ack,
  output logic [31:0]      rd_data,
  output logic [15:0]      mii_rd_data,
  input  wire logic        adv_sym_pause,
  input  wire logic        adv_asym_pause,
  input  wire logic [3:0]  adv_ability,
  input  wire logic        an_complete,
  input  wire logic        port0_duplex_pin,
  input  wire logic        speed_strap_pin,
  input  wire logic        duplex_pol_strap_pin,
  input  wire logic        full_duplex_flow_strap,
  output logic             partner_an_able,
  output logic [15:0]      partner_word
);

  logic        speed_strap_q;
  logic        duplex_pol_q;
  logic        flow_strap_q;
  logic        duplex_sync;
  logic [1:0]  pause_q;
  logic [3:0]  ability_q;
  logic        hit_q;
  logic [15:0] word;

  elpa_sync #(
    .RST_VAL (1'b0)
  ) u_duplex_sync (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .pin_in    (port0_duplex_pin),
    .level_out (duplex_sync)
  );

  // straps follow their pins while reset is held; the last value before
  // release is kept, so they must be steady across the release edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      speed_strap_q <= speed_strap_pin;                        // RULE12
      duplex_pol_q  <= duplex_pol_strap_pin;                   // RULE12
      flow_strap_q  <= full_duplex_flow_strap;                 // RULE12
    end
  end

  // pause bits only move on completion, later advertisement edits wait
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pause_q <= elpa_pkg::PAUSE_RST;
    end else if (an_complete) begin
      pause_q <= elpa_pkg::pause_map(adv_sym_pause, adv_asym_pause,
                                     flow_strap_q);            // RULE8 RULE9
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ability_q <= elpa_pkg::ABIL_RST;
    end else begin
      ability_q <= elpa_pkg::ability_map(duplex_sync == duplex_pol_q,
                                         speed_strap_q);     // RULE10 RULE11
    end
  end

  // no shared ability bit means the emulated negotiation failed
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      partner_an_able <= 1'b0;
    end else begin
      partner_an_able <= |(adv_ability & ability_q);           // RULE13
    end
  end

  always_comb begin
    word = 16'h0000;
    word[elpa_pkg::BIT_NEXT_PAGE]    = elpa_pkg::NEXT_PAGE_VAL;    // RULE2
    word[elpa_pkg::BIT_ACK]          = elpa_pkg::ACK_VAL;          // RULE3
    word[elpa_pkg::BIT_REMOTE_FAULT] = elpa_pkg::REMOTE_FAULT_VAL; // RULE4
    word[elpa_pkg::BIT_RSVD12]       = elpa_pkg::RSVD_VAL;         // RULE14
    word[elpa_pkg::BIT_ASYM_PAUSE]   = pause_q[1];                 // RULE8
    word[elpa_pkg::BIT_SYM_PAUSE]    = pause_q[0];                 // RULE8
    word[elpa_pkg::BIT_T4]           = elpa_pkg::T4_VAL;           // RULE5
    word[elpa_pkg::ABIL_HI:elpa_pkg::ABIL_LO] = ability_q;
    word[elpa_pkg::SEL_HI:elpa_pkg::SEL_LO]   =
      elpa_pkg::SEL_IEEE_8023;                                     // RULE6
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      partner_word <= 16'h0000;
    end else begin
      partner_word <= word;
    end
  end

  // read path; unmapped indices read zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd_valid    <= 1'b0;
      hit_q       <= 1'b0;
      rd_data     <= 32'h0000_0000;
      mii_rd_data <= 16'h0000;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        hit_q <= (reg_index == elpa_pkg::IDX_PARTNER_ABIL);
        if (reg_index == elpa_pkg::IDX_PARTNER_ABIL) begin
          rd_data     <= {elpa_pkg::PAD_VAL, word};            // RULE7
          mii_rd_data <= word;                                 // RULE7
        end else begin
          rd_data     <= 32'h0000_0000;
          mii_rd_data <= 16'h0000;
        end
      end
    end
  end

  // writes are acknowledged and dropped; nothing here has a write path
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_ack <= 1'b0;
    end else begin
      wr_ack <= wr_en;                                         // RULE1
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_hit_read;
    rd_valid && hit_q;
  endsequence

  sequence s_complete;
    an_complete ##1 1'b1;
  endsequence

  AST_RO_WRITE: assert property (                             // RULE1
    (wr_en && !an_complete) |=> ($stable(pause_q) && wr_ack))
    else $error("write disturbed partner pause bits");

  AST_NEXT_PAGE: assert property (                            // RULE2
    s_hit_read |-> (rd_data[15] == 1'b0))
    else $error("next page bit not zero");

  AST_ACK: assert property (                                  // RULE3
    s_hit_read |-> (rd_data[14] == 1'b1))
    else $error("acknowledge bit not one");

  AST_FAULT: assert property (                                // RULE4
    s_hit_read |-> (rd_data[13] == 1'b0))
    else $error("remote fault bit not zero");

  AST_T4: assert property (                                   // RULE5
    s_hit_read |-> (rd_data[9] == 1'b0))
    else $error("100BASE-T4 bit not zero");

  AST_SELECTOR: assert property (                             // RULE6
    s_hit_read |-> (rd_data[4:0] == 5'h01))
    else $error("selector field wrong");

  AST_PAD: assert property (                                  // RULE7
    rd_valid |-> (rd_data[31:16] == 16'h0000 &&
                  rd_data[15:0] == mii_rd_data))
    else $error("padding or management view wrong");

  AST_PAUSE_MAP: assert property (                            // RULE8
    (an_complete && adv_sym_pause && adv_asym_pause) |=>
      (pause_q == (flow_strap_q ? 2'h3 : 2'h2)))
    else $error("pause result for both advertised wrong");

  AST_PAUSE_HOLD: assert property (                           // RULE9
    (!an_complete && !$rose(an_complete)) |=> $stable(pause_q))
    else $error("pause bits moved without completion");

  // partner asym follows adv asym; partner sym is set unless both or none,
  // and with both advertised it follows the flow strap
  AST_PAUSE_CAPTURE: assert property (                        // RULE9
    s_complete |-> (pause_q[1] == $past(adv_asym_pause) &&
      pause_q[0] == $past((adv_sym_pause ^ adv_asym_pause) ||
                          (adv_sym_pause && adv_asym_pause &&
                           flow_strap_q)))
      ##1 (partner_word[11:10] == $past(pause_q, 1)))
    else $error("captured pause not presented");

  AST_DUP_MATCH: assert property (                            // RULE10
    (duplex_sync == duplex_pol_q) ##1 $stable(duplex_sync) |->
      (ability_q == (speed_strap_q ? 4'h8 : 4'h2)))
    else $error("full duplex ability wrong");

  AST_DUP_DIFF: assert property (                             // RULE11
    (duplex_sync != duplex_pol_q) ##1 $stable(duplex_sync) |->
      (ability_q == (speed_strap_q ? 4'h4 : 4'h1)))
    else $error("half duplex ability wrong");

  AST_STRAP_KEEP: assert property (                           // RULE12
    $stable(speed_strap_q) && $stable(duplex_pol_q) &&
    $stable(flow_strap_q))
    else $error("strap changed after reset");

  AST_AN_ABLE: assert property (                              // RULE13
    ((adv_ability & ability_q) == 4'h0) |=> !partner_an_able)
    else $error("able shown with no common ability");

  AST_AN_ABLE_SET: assert property (                          // RULE13
    ((adv_ability & ability_q) != 4'h0) |=> partner_an_able)
    else $error("able not shown with common ability");

  AST_RSVD12: assert property (                               // RULE14
    s_hit_read |-> (rd_data[12] == 1'b0))
    else $error("reserved bit 12 not zero");

endmodule : elpa_top

//--- hw/elpa_pkg.sv
// Summary of operation
// RULE1: register is read-only, writes change nothing
// RULE2: bit 15 next page reads zero
// RULE3: bit 14 acknowledge reads one
// RULE4: bit 13 remote fault reads zero
// RULE5: bit 9 100BASE-T4 reads zero
// RULE6: selector bits 4:0 read IEEE 802.3
// RULE7: upper half zero; management sees 16 bits
// RULE8: pause bits mirror advertisement per table
// RULE9: pause bits captured at negotiation complete
// RULE10: duplex match gives 0010 or 1000
// RULE11: duplex mismatch gives 0001 or 0100
// RULE12: straps latched at reset release, then kept
// RULE13: no common ability means negotiation failed
// RULE14: bit 12 reserved reads zero
package elpa_pkg;

  localparam int          IDX_W              = 5;
  localparam logic [4:0]  IDX_PARTNER_ABIL   = 5'h05;
  localparam int          REG_W              = 32;
  localparam int          MII_W              = 16;

  localparam int          BIT_NEXT_PAGE      = 15;
  localparam int          BIT_ACK            = 14;
  localparam int          BIT_REMOTE_FAULT   = 13;
  localparam int          BIT_RSVD12         = 12;
  localparam int          BIT_ASYM_PAUSE     = 11;
  localparam int          BIT_SYM_PAUSE      = 10;
  localparam int          BIT_T4             = 9;
  localparam int          ABIL_HI            = 8;
  localparam int          ABIL_LO            = 5;
  localparam int          SEL_HI             = 4;
  localparam int          SEL_LO             = 0;

  localparam logic        NEXT_PAGE_VAL      = 1'b0;
  localparam logic        ACK_VAL            = 1'b1;
  localparam logic        REMOTE_FAULT_VAL   = 1'b0;
  localparam logic        RSVD_VAL           = 1'b0;
  localparam logic        T4_VAL             = 1'b0;
  localparam logic [4:0]  SEL_IEEE_8023      = 5'h01;
  localparam logic [15:0] PAD_VAL            = 16'h0000;

  localparam logic [3:0]  ABIL_10_FULL       = 4'h2;
  localparam logic [3:0]  ABIL_100_FULL      = 4'h8;
  localparam logic [3:0]  ABIL_10_HALF       = 4'h1;
  localparam logic [3:0]  ABIL_100_HALF      = 4'h4;
  localparam logic [3:0]  ABIL_RST           = 4'h0;
  localparam logic [1:0]  PAUSE_RST          = 2'h0;
  localparam logic        STRAP_RST          = 1'b0;

  // returns {asymmetric, symmetric} as seen from the emulated partner
  function automatic logic [1:0] pause_map(input logic adv_sym,
                                           input logic adv_asym,
                                           input logic flow_strap);
    logic [1:0] res;
    res = 2'h0;
    case ({adv_sym, adv_asym})
      2'b00:   res = 2'h0;
      2'b10:   res = 2'h1;
      2'b01:   res = 2'h3;
      2'b11:   res = flow_strap ? 2'h3 : 2'h2;
      default: res = 2'h0;
    endcase
    return res;
  endfunction : pause_map

  function automatic logic [3:0] ability_map(input logic dup_match,
                                             input logic speed_strap);
    logic [3:0] res;
    res = ABIL_RST;
    if (dup_match) begin
      res = speed_strap ? ABIL_100_FULL : ABIL_10_FULL;
    end else begin
      res = speed_strap ? ABIL_100_HALF : ABIL_10_HALF;
    end
    return res;
  endfunction : ability_map

endpackage : elpa_pkg

//--- hw/elpa_sync.sv
// three stage pin synchroniser; output moves only when stages 2 and 3 agree
module elpa_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // agreement filter ignores a one-cycle glitch reaching stage 2
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      level_out <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end

endmodule : elpa_sync

//--- bench/elpa_host.sv
// management host: one-cycle request pulses, bounded wait for the answer
module elpa_host (
  input  wire logic        core_clk,
  output logic             rd_en,
  output logic             wr_en,
  output logic [4:0]       reg_index,
  output logic [31:0]      wr_data,
  input  wire logic        rd_valid,
  input  wire logic        wr_ack,
  input  wire logic [31:0] rd_data,
  input  wire logic [15:0] mii_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rd_en = 1'b0;
    wr_en = 1'b0;
    reg_index = 5'h00;
    wr_data = 32'h00000000;
  end

  // a held request would be taken twice, so the pulse drops after one edge
  task automatic read(input logic [4:0] a, output logic [31:0] d,
                      output logic [15:0] m, output bit ok);
    ok = 1'b0;
    reg_index = a;
    rd_en = 1'b1;
    @(posedge core_clk);
    #1;
    rd_en = 1'b0;
    reg_index = ~a;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rd_data;
        m = mii_rd_data;
      end else begin
        @(posedge core_clk);
        #1;
      end
    end
    @(posedge core_clk);
    #1;
  endtask : read

  task automatic write(input logic [4:0] a, input logic [31:0] d,
                       output bit ok);
    ok = 1'b0;
    reg_index = a;
    wr_data = d;
    wr_en = 1'b1;
    @(posedge core_clk);
    #1;
    wr_en = 1'b0;
    wr_data = ~d;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (wr_ack === 1'b1) begin
        ok = 1'b1;
      end else begin
        @(posedge core_clk);
        #1;
      end
    end
    @(posedge core_clk);
    #1;
  endtask : write
endmodule : elpa_host

//--- bench/elpa_top_tb.sv
module elpa_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_b, adv_sym, adv_asym, an_done, dpin, spd;
  logic        pol, flow, rd_en, wr_en, rd_valid, wr_ack, an_able, fl;
  logic [3:0]  adv_ab, ab;
  logic [1:0]  pz;
  logic [4:0]  idx;
  logic [31:0] wdat, rdat;
  logic [15:0] mii, pword;
  bit          ok;
  int          fails, checks_done;
  // {speed, polarity, flow, duplex pin}: all four abilities, both flows
  logic [3:0]  cfgs [4] = '{4'h0, 4'h9, 4'h3, 4'hF};
  logic [1:0]  pt [4] = '{2'h0, 2'h3, 2'h1, 2'h2};

  elpa_top i_elpa_top (.core_clk(core_clk), .rst_b(rst_b), .rd_en(rd_en),
    .wr_en(wr_en), .reg_index(idx), .wr_data(wdat), .rd_valid(rd_valid),
    .wr_ack(wr_ack), .rd_data(rdat), .mii_rd_data(mii),
    .adv_sym_pause(adv_sym), .adv_asym_pause(adv_asym),
    .adv_ability(adv_ab), .an_complete(an_done), .port0_duplex_pin(dpin),
    .speed_strap_pin(spd), .duplex_pol_strap_pin(pol),
    .full_duplex_flow_strap(flow), .partner_an_able(an_able),
    .partner_word(pword));
  elpa_host i_elpa_host (.core_clk(core_clk), .rd_en(rd_en), .wr_en(wr_en),
    .reg_index(idx), .wr_data(wdat), .rd_valid(rd_valid), .wr_ack(wr_ack),
    .rd_data(rdat), .mii_rd_data(mii));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [15:0] m;
    bit          k;
    i_elpa_host.read(a, d, m, k);
    if (!k) begin
      chk("rd_valid", 32'h1, 32'h0);
      results();
    end
    chk("rd_data", e, d);
    chk("mii_rd_data", {16'h0000, e[15:0]}, {16'h0000, m});
  endtask : rd

  function automatic logic [31:0] wd(input logic [1:0] p,
                                     input logic [3:0] a);
    return {16'h0000, 4'h4, p, 1'h0, a, 5'h01};
  endfunction : wd

  initial begin
    {rst_b, adv_sym, adv_asym, an_done, dpin, spd, pol, flow} = 8'h00;
    adv_ab = 4'h0;
    fails = 0;
    checks_done = 0;
    for (int c = 0; c < 4; c++) begin
      {spd, pol, flow, dpin} = cfgs[c];
      fl = flow;
      ab = (dpin == pol) ? (spd ? 4'h8 : 4'h2) : (spd ? 4'h4 : 4'h1);
      rst_b = 1'b0;
      cyc(10);
      rst_b = 1'b1;
      cyc(1);
      // straps move after release; the latched copy must win
      {spd, pol, flow} = ~{spd, pol, flow};
      cyc(8);
      rd(5'h05, wd(2'h0, ab));
      chk("partner_word", wd(2'h0, ab), {16'h0000, pword});
      for (int j = 0; j < 4; j++) begin
        {adv_sym, adv_asym} = j[1:0];
        an_done = 1'b1;
        cyc(1);
        an_done = 1'b0;
        cyc(2);
        pz = (j == 3 && fl) ? 2'h3 : pt[j];
        rd(5'h05, wd(pz, ab));
      end
      {adv_sym, adv_asym} = 2'h0;
      cyc(2);
      rd(5'h05, wd(pz, ab));
      i_elpa_host.write(5'h05, 32'hFFFFFFFF, ok);
      chk("wr_ack", 32'h1, {31'h0, ok});
      rd(5'h05, wd(pz, ab));
      rd(5'h06, 32'h00000000);
      adv_ab = ab;
      cyc(2);
      chk("partner_an_able", 32'h1, {31'h0, an_able});
      adv_ab = ~ab;
      cyc(2);
      chk("partner_an_able", 32'h0, {31'h0, an_able});
    end
    results();
  end
endmodule : elpa_top_tb
